// ---- logic/rfl_pkg.sv ----
// Operation
// R1: Sixty-four product terms from sixteen inputs, each in true and complemented form.
// R2: Eight fixed OR functions, each summing its own eight terms, none shared.
// R3: A term is true when every input joined by intact fuse matches.
// R4: A term with every fuse programmed stays permanently high.
// R5: A term joined to both forms of one input stays low.
// R6: An unprogrammed part shows every product term low.
// R7: Per-output polarity fuse; intact gives active high, programmed gives active low.
// R8: Each polarity-adjusted sum is captured by a rising-edge D flip-flop.
// R9: Eight dedicated inputs plus eight registered outputs fed back into the array.
// R10: All eight outputs come from registers through an output enable gate.
// R11: An undriven input pin reads as logic low, like a pull-down.
// R12: A programmed security fuse refuses fuse readback; the logic keeps working.
// R13: Split-clock option: two register groups, grouping set by a parameter.
// R14: Fuse map is static configuration; output registers have no reset.
package rfl_pkg;

    // Array geometry.
    localparam int NUM_DED = 8;
    localparam int NUM_OUT = 8;
    localparam int NUM_IN = NUM_DED + NUM_OUT;
    localparam int TERMS_PER_OR = 8;
    localparam int NUM_TERMS = NUM_OUT * TERMS_PER_OR;
    localparam int FUSE_W = 2 * NUM_IN;

    // Fuse layout in a term word: bit 2i joins input i, bit 2i+1 its complement.
    localparam int FUSE_TRUE_OFS = 0;
    localparam int FUSE_COMP_OFS = 1;

    // APB register map, byte addresses.
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_FUSE_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_FUSE_LAST = 12'h0FC;
    localparam logic [ADDR_W-1:0] ADDR_POLARITY = 12'h100;
    localparam logic [ADDR_W-1:0] ADDR_SECURITY = 12'h104;
    localparam logic [ADDR_W-1:0] ADDR_OUT_EN = 12'h108;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h10C;
    localparam logic [ADDR_W-1:0] ADDR_TERM_LO = 12'h110;
    localparam logic [ADDR_W-1:0] ADDR_TERM_HI = 12'h114;
    localparam logic [ADDR_W-1:0] ADDR_SUMS = 12'h118;
    localparam int WORD_LSB = 2;
    localparam int FUSE_IDX_W = 6;

    // Reset values: all fuses intact is the unprogrammed part.
    localparam logic [FUSE_W-1:0] FUSE_INTACT = 32'hFFFF_FFFF;
    localparam logic [NUM_OUT-1:0] POL_INTACT = 8'h00;
    localparam logic [NUM_OUT-1:0] OE_RESET = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // Status word fields.
    localparam int STAT_OUT_LSB = 0;
    localparam int STAT_LOADED_LSB = 8;
    localparam int STAT_SEC_BIT = 16;

    // Split clock defaults: upper four registers on the second clock.
    localparam logic [NUM_OUT-1:0] CLK_B_MASK_DEF = 8'hF0;

endpackage

// ---- logic/rfl_product_term.sv ----
`timescale 1ns/10ps
module rfl_product_term
    import rfl_pkg::*;
#(
    parameter int N_IN = NUM_IN
) (
    // Array inputs and this term's fuse word.
    input wire logic [N_IN-1:0] lines,
    input wire logic [2*N_IN-1:0] fuses,
    // Term value.
    output logic term
);

    logic [2*N_IN-1:0] literal;
    logic [2*N_IN-1:0] pass;

    always_comb begin
        for (int i = 0; i < N_IN; i++) begin
            literal[2*i+FUSE_TRUE_OFS] = lines[i];  // see R1
            literal[2*i+FUSE_COMP_OFS] = ~lines[i];  // see R1
        end
    end

    // A blown fuse forces its literal true; intact literals must all match.
    assign pass = ~fuses | literal;  // see R3
    // No intact fuse leaves every pass bit high, so the term stays high.
    assign term = &pass;  // see R4
    // Both literals of one input intact can never be true together.
    // The unprogrammed word of all ones therefore yields a low term.
    // see R5
    // see R6

endmodule

// ---- logic/rfl_logic_array.sv ----
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
module rfl_logic_array
    import rfl_pkg::*;
#(
    parameter logic SPLIT_CLOCKS = 1'b0,
    parameter logic [NUM_OUT-1:0] CLK_B_MASK = CLK_B_MASK_DEF
) (
    // APB clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Dedicated input pins, each with a driven flag.
    input wire logic [NUM_DED-1:0] ded_in,
    input wire logic [NUM_DED-1:0] ded_drv,
    // Register clock pins.
    input wire logic reg_clk_a,
    input wire logic reg_clk_a_drv,
    input wire logic reg_clk_b,
    input wire logic reg_clk_b_drv,
    // Output pins.
    output logic [NUM_OUT-1:0] out_o,
    output logic [NUM_OUT-1:0] out_oe
);

    // Pin synchronisers.
    logic [NUM_DED-1:0] ded_meta_q;
    logic [NUM_DED-1:0] ded_sync_q;
    logic [NUM_DED-1:0] drv_meta_q;
    logic [NUM_DED-1:0] drv_sync_q;
    logic [1:0] clk_meta_q;
    logic [1:0] clk_sync_q;
    logic [1:0] cdrv_meta_q;
    logic [1:0] cdrv_sync_q;
    logic [1:0] clk_prev_q;
    logic [NUM_DED-1:0] ded_pin;
    logic [1:0] clk_pin;
    logic [1:0] clk_rise;

    // Fuse map and control.
    logic [FUSE_W-1:0] fuse_q [NUM_TERMS];
    logic [FUSE_W-1:0] fuse_d [NUM_TERMS];
    logic [NUM_OUT-1:0] pol_q;
    logic [NUM_OUT-1:0] pol_d;
    logic sec_q;
    logic sec_d;
    logic [NUM_OUT-1:0] oe_q;
    logic [NUM_OUT-1:0] oe_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;
    logic fuse_we;
    logic [FUSE_IDX_W-1:0] fuse_idx;

    // Array and output registers.
    logic [NUM_IN-1:0] lines;
    logic [NUM_TERMS-1:0] terms;
    logic [NUM_OUT-1:0] sums;
    logic [NUM_OUT-1:0] next_out;
    logic [NUM_OUT-1:0] load;
    logic [NUM_OUT-1:0] out_q;
    logic [NUM_OUT-1:0] out_d;
    logic [NUM_OUT-1:0] loaded_q;
    logic [NUM_OUT-1:0] loaded_d;

    // APB decode.
    logic setup;
    logic access_wr;
    logic in_fuse;

    // Floating pins read low, as a pull-down would make them.
    // The driven flags are synchronised too, so no logic sees a raw pin.
    assign ded_pin = ded_sync_q & drv_sync_q;  // see R11
    assign clk_pin = clk_sync_q & cdrv_sync_q;  // see R11

    // Two flops per pin before any logic looks at the level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ded_meta_q <= '0;
            ded_sync_q <= '0;
            drv_meta_q <= '0;
            drv_sync_q <= '0;
            clk_meta_q <= '0;
            clk_sync_q <= '0;
            cdrv_meta_q <= '0;
            cdrv_sync_q <= '0;
            clk_prev_q <= '0;
        end else begin
            ded_meta_q <= ded_in;
            ded_sync_q <= ded_meta_q;
            drv_meta_q <= ded_drv;
            drv_sync_q <= drv_meta_q;
            clk_meta_q <= {reg_clk_b, reg_clk_a};
            clk_sync_q <= clk_meta_q;
            cdrv_meta_q <= {reg_clk_b_drv, reg_clk_a_drv};
            cdrv_sync_q <= cdrv_meta_q;
            clk_prev_q <= clk_pin;
        end
    end

    // Only the low-to-high transition of a register clock loads.
    assign clk_rise = clk_pin & ~clk_prev_q;  // see R8

    // Array inputs: dedicated pins low, registered feedback high.
    assign lines = {out_q, ded_pin};  // see R9

    genvar t;
    generate
        for (t = 0; t < NUM_TERMS; t++) begin : g_term
            rfl_product_term #(
                .N_IN(NUM_IN)
            ) u_term (
                .lines(lines),
                .fuses(fuse_q[t]),
                .term(terms[t])
            );  // see R1
        end
    endgenerate

    // Each output sums its own slice of eight terms, never a neighbour's.
    genvar o;
    generate
        for (o = 0; o < NUM_OUT; o++) begin : g_sum
            assign sums[o] = |terms[o*TERMS_PER_OR +: TERMS_PER_OR];  // see R2
        end
    endgenerate

    // A programmed polarity fuse inverts the sum.
    assign next_out = sums ^ pol_q;  // see R7

    // Clock group choice per register.
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            if (SPLIT_CLOCKS && CLK_B_MASK[i]) begin
                load[i] = clk_rise[1];  // see R13
            end else begin
                load[i] = clk_rise[0];  // see R13
            end
        end
    end

    always_comb begin
        out_d = out_q;
        loaded_d = loaded_q;
        for (int i = 0; i < NUM_OUT; i++) begin
            if (load[i]) begin
                out_d[i] = next_out[i];  // see R8
                loaded_d[i] = 1'b1;
            end
        end
    end

    // Output registers power up unknown; no reset reaches them.
    always_ff @(posedge pclk) begin
        out_q <= out_d;  // see R14
    end

    // Tracks which registers hold a real value, so a pin never drives X.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_q <= '0;
        end else begin
            loaded_q <= loaded_d;
        end
    end

    // The data pins come straight from the registers.
    assign out_o = out_q;  // see R10
    // The enable gate can release any pin; it also holds off an unloaded one.
    assign out_oe = oe_q & loaded_q;  // see R10

    // APB slave, zero wait states.
    assign setup = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign in_fuse = paddr <= ADDR_FUSE_LAST;
    assign fuse_idx = paddr[WORD_LSB +: FUSE_IDX_W];
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    always_comb begin
        pol_d = pol_q;
        sec_d = sec_q;
        oe_d = oe_q;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        fuse_we = 1'b0;
        if (access_wr) begin
            if (in_fuse) begin
                fuse_we = 1'b1;
            end else if (paddr == ADDR_POLARITY) begin
                // Polarity fuses, like array fuses, only ever get blown.
                pol_d = pol_q | pwdata[NUM_OUT-1:0];  // see R7
            end else if (paddr == ADDR_SECURITY) begin
                sec_d = sec_q | pwdata[0];  // see R12
            end else if (paddr == ADDR_OUT_EN) begin
                oe_d = pwdata[NUM_OUT-1:0];
            end
        end
        if (setup) begin
            prdata_d = RD_ZERO;
            pslverr_d = 1'b0;
            if (in_fuse) begin
                if (pwrite) begin
                    pslverr_d = 1'b0;
                end else if (sec_q) begin
                    // Fuse pattern is no longer verifiable.
                    pslverr_d = 1'b1;  // see R12
                end else begin
                    prdata_d = fuse_q[fuse_idx];
                end
            end else if (paddr == ADDR_POLARITY) begin
                if (!pwrite && sec_q) begin
                    pslverr_d = 1'b1;  // see R12
                end else if (!pwrite) begin
                    prdata_d[NUM_OUT-1:0] = pol_q;
                end
            end else if (paddr == ADDR_SECURITY) begin
                prdata_d[0] = sec_q;
            end else if (paddr == ADDR_OUT_EN) begin
                prdata_d[NUM_OUT-1:0] = oe_q;
            end else if (paddr == ADDR_STATUS) begin
                prdata_d[STAT_OUT_LSB +: NUM_OUT] = out_q & loaded_q;
                prdata_d[STAT_LOADED_LSB +: NUM_OUT] = loaded_q;
                prdata_d[STAT_SEC_BIT] = sec_q;
            end else if (paddr == ADDR_TERM_LO) begin
                prdata_d = terms[31:0];
            end else if (paddr == ADDR_TERM_HI) begin
                prdata_d = terms[NUM_TERMS-1:32];
            end else if (paddr == ADDR_SUMS) begin
                prdata_d[NUM_OUT-1:0] = sums;
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_q <= POL_INTACT;
            sec_q <= 1'b0;
            oe_q <= OE_RESET;
            prdata_q <= RD_ZERO;
            pslverr_q <= 1'b0;
        end else begin
            pol_q <= pol_d;
            sec_q <= sec_d;
            oe_q <= oe_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Fuse map: loaded once before use; a one in the write blows that fuse.
    // Reset returns the map to the unprogrammed state, since a model has no
    // other way to start over.
    always_comb begin
        for (int i = 0; i < NUM_TERMS; i++) begin
            fuse_d[i] = fuse_q[i];
        end
        if (fuse_we) begin
            fuse_d[fuse_idx] = fuse_q[fuse_idx] & ~pwdata;  // see R14
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_TERMS; i++) begin
                fuse_q[i] <= FUSE_INTACT;  // see R6
            end
        end else begin
            for (int i = 0; i < NUM_TERMS; i++) begin
                fuse_q[i] <= fuse_d[i];
            end
        end
    end

endmodule

// ---- dv/rfl_checker.sv ----
`timescale 1ns/10ps
module rfl_checker
    import rfl_pkg::*;
(
    // Bus side.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Pin side.
    input wire logic reg_clk_a,
    input wire logic reg_clk_b,
    input wire logic [NUM_OUT-1:0] out_o,
    input wire logic [NUM_OUT-1:0] out_oe
);
    logic wrx, rdx, ck, sec_q, sec_d, seen_q, seen_d;
    logic [NUM_OUT-1:0] oe_q, oe_d;
    assign wrx = psel && penable && pwrite;
    assign rdx = psel && penable && !pwrite;
    assign ck = reg_clk_a || reg_clk_b;
    always_comb begin
        sec_d = sec_q || (wrx && paddr == ADDR_SECURITY && pwdata[0]);
        seen_d = seen_q || ck;
        oe_d = (wrx && paddr == ADDR_OUT_EN) ? pwdata[7:0] : oe_q;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_q <= 1'h0;
            seen_q <= 1'h0;
            oe_q <= OE_RESET;
        end else begin
            sec_q <= sec_d;
            seen_q <= seen_d;
            oe_q <= oe_d;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_OUT_HOLD: assert property ($changed(out_o) |->
        $past(ck, 2) || $past(ck, 3) || $past(ck, 4) || $past(ck, 5))
        else $error("output moved without a clock pin rise");
    AST_OE_RESET: assert property ($rose(presetn) |-> out_oe == 8'h00)
        else $error("output enable not off after reset");
    AST_OE_GATE: assert property ((out_oe & ~oe_q) == 8'h00)
        else $error("output enabled while its enable bit is clear");
    AST_OE_LOAD: assert property (out_oe != 8'h00 |-> seen_q)
        else $error("output enabled before any load");
    AST_SEC_REFUSE: assert property (rdx && sec_q && paddr <= ADDR_POLARITY
        |-> pslverr && prdata == RD_ZERO) else $error("secured read served");
    AST_OPEN_READ: assert property (rdx && !sec_q && paddr <= ADDR_FUSE_LAST
        |-> !pslverr) else $error("open fuse read refused");
    AST_STAT_SEC: assert property (rdx && paddr == ADDR_STATUS
        |-> prdata[STAT_SEC_BIT] == sec_q) else $error("status lost lock");
    AST_STAT_OUT: assert property (rdx && paddr == ADDR_STATUS
        |-> prdata[7:0] == (out_o & prdata[15:8]))
        else $error("status outputs differ from pins");
endmodule
bind rfl_logic_array rfl_checker i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .reg_clk_a(reg_clk_a), .reg_clk_b(reg_clk_b), .out_o(out_o),
    .out_oe(out_oe));

// ---- dv/rfl_far_logic.sv ----
`timescale 1ns/10ps
module rfl_far_logic
    import rfl_pkg::*;
(
    // Reference clock.
    input wire logic pclk,
    // Pins into the array.
    output logic [NUM_DED-1:0] ded_in,
    output logic [NUM_DED-1:0] ded_drv,
    output logic reg_clk_a,
    output logic reg_clk_a_drv,
    output logic reg_clk_b,
    output logic reg_clk_b_drv
);
    initial begin
        ded_in = 8'h00;
        ded_drv = 8'hFF;
        reg_clk_a = 1'h0;
        reg_clk_a_drv = 1'h1;
        reg_clk_b = 1'h0;
        reg_clk_b_drv = 1'h1;
    end
    // A released pin shows the inverse level, so only the pull-down
    // can make it read low.
    task automatic apply(input logic [7:0] v, input logic [7:0] d);
        ded_in <= v ^ ~d;
        ded_drv <= d;
        @(posedge pclk);
    endtask
    // Data is held four cycles either side of the rise, above the margin.
    task automatic pulse(input logic [1:0] w);
        repeat (4) @(posedge pclk);
        reg_clk_a <= w[0];
        reg_clk_b <= w[1];
        repeat (4) @(posedge pclk);
        reg_clk_a <= 1'h0;
        reg_clk_b <= 1'h0;
        repeat (4) @(posedge pclk);
    endtask
endmodule

// ---- dv/rfl_logic_array_tb.sv ----
`timescale 1ns/10ps
module rfl_logic_array_tb;
    import rfl_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pready, pslverr, er, ca, cad, cb, cbd;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] ded_in, ded_drv, out_o, out_oe;
    int err_count = 0, n_tests = 0, cyc = 0;
    logic [11:0] fa [7] = '{12'h000, 12'h020, 12'h040, 12'h060, 12'h064,
        12'h080, 12'h0A0};
    logic [31:0] fd [7] = '{32'hFFFF_FFFE, 32'hFFFF_FFFF, 32'hFFFF_FFF3,
        32'hFFFF_FF9F, 32'hFFFF_FEFF, 32'hFFFF_FFFE, 32'hFFFE_FFFF};
    // Rows: pin level, driven mask, expected outputs.
    logic [23:0] rows [5] = '{24'h01FF83, 24'h1CFFBA, 24'h000092,
        24'h0D0783, 24'h08FFBA};
    always #5 pclk = ~pclk;
    rfl_logic_array #(.SPLIT_CLOCKS(1'h1)) i_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ded_in(ded_in), .ded_drv(ded_drv),
        .reg_clk_a(ca), .reg_clk_a_drv(cad), .reg_clk_b(cb),
        .reg_clk_b_drv(cbd), .out_o(out_o), .out_oe(out_oe));
    rfl_far_logic i_far (.pclk(pclk), .ded_in(ded_in), .ded_drv(ded_drv),
        .reg_clk_a(ca), .reg_clk_a_drv(cad), .reg_clk_b(cb),
        .reg_clk_b_drv(cbd));
    task automatic test_done();
        $display("compares %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic step(logic [7:0] v, logic [1:0] w, logic [7:0] e);
        i_far.apply(v, 8'hFF);
        i_far.pulse(w);
        chk("outputs", {24'h0, e}, {24'h0, out_o});
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, 12'h000, 0);
        chk("fuse word", FUSE_INTACT, rd);
        apb(1'h0, ADDR_TERM_LO, 0);
        chk("terms", 0, rd);
        apb(1'h0, ADDR_STATUS, 0);
        chk("status", 0, rd);
        apb(1'h1, ADDR_OUT_EN, 32'hFF);
        chk("enable", 0, {24'h0, out_oe});
        chk("pready", 32'h1, {31'h0, pready});
        $display("reset test done");
        for (int i = 0; i < 7; i++) apb(1'h1, fa[i], fd[i]);
        apb(1'h1, ADDR_POLARITY, 32'h90);
        apb(1'h1, 12'h000, 0);
        apb(1'h0, 12'h000, 0);
        chk("fuse word", ~fd[0], rd);
        i_far.apply(8'h00, 8'hFF);
        repeat (2) i_far.pulse(2'h3);
        for (int i = 0; i < 5; i++) begin
            i_far.apply(rows[i][23:16], rows[i][15:8]);
            i_far.pulse(2'h3);
            chk("outputs", rows[i][7:0], {24'h0, out_o});
            chk("enable", 32'hFF, {24'h0, out_oe});
        end
        $display("array test done");
        step(8'h01, 2'h1, 8'hB3);
        step(8'h01, 2'h2, 8'hA3);
        apb(1'h0, ADDR_STATUS, 0);
        chk("status", 32'h0000_FFA3, rd);
        apb(1'h0, ADDR_SUMS, 0);
        chk("sums", 32'h33, rd);
        apb(1'h0, ADDR_TERM_LO, 0);
        chk("terms lo", 32'h101, rd);
        apb(1'h0, ADDR_TERM_HI, 0);
        chk("terms hi", 32'h101, rd);
        apb(1'h0, ADDR_POLARITY, 0);
        chk("polarity", 32'h90, rd);
        apb(1'h0, ADDR_OUT_EN, 0);
        chk("enable reg", 32'hFF, rd);
        $display("split clock test done");
        apb(1'h1, ADDR_SECURITY, 1);
        apb(1'h0, 12'h000, 0);
        chk("locked fuse", 32'h1, {31'h0, er});
        chk("locked fuse data", 32'h0, rd);
        apb(1'h0, ADDR_POLARITY, 0);
        chk("locked polarity", 32'h1, {31'h0, er});
        chk("locked polarity data", 32'h0, rd);
        apb(1'h0, ADDR_SECURITY, 0);
        chk("security", 32'h1, rd);
        apb(1'h0, 12'h200, 0);
        chk("unmapped", 1, {31'h0, er});
        step(8'h1C, 2'h3, 8'hBA);
        apb(1'h0, ADDR_STATUS, 0);
        chk("status", 32'h0001_FFBA, rd);
        $display("security test done");
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk("held outputs", 32'hBA, {24'h0, out_o});
        chk("enable", 0, {24'h0, out_oe});
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, 12'h000, 0);
        chk("fuse word", FUSE_INTACT, rd);
        apb(1'h0, ADDR_STATUS, 0);
        chk("status", 0, rd);
        $display("mid-run reset test done");
        test_done();
    end
endmodule
